// file: pkg/ccp_consts.vh
// constants for the compare and pwm unit
`ifndef CCP_CONSTS_VH
`define CCP_CONSTS_VH

`define MODE_OFF        4'h0
`define MODE_CMP_SET    4'h8
`define MODE_CMP_CLR    4'h9
`define MODE_CMP_SWI    4'hA
`define MODE_CMP_SPEV   4'hB
`define MODE_PWM_MASK   4'hC
`define CTRL_MODE_MSB   3
`define CTRL_DLOW_MSB   5
`define CTRL_DLOW_LSB   4
`define CTRL_WIDTH      6
`define PRESC_1         2'h0
`define PRESC_4         2'h1
`define PRESC_16        2'h2
`define PHASE_INC       2'h1
`define PHASE_TOP       2'h3
`define ZERO_DUTY       10'h000

`endif

// file: hdl/duty_buffer.v
// double buffer for the pwm duty value, loaded at period end
`timescale 1ns/1ps
`default_nettype none
module duty_buffer #(
  parameter DW = 10
) (
  input  wire          clk_sys,
  input  wire          rst_b,
  input  wire          clear,
  input  wire          load,
  input  wire [DW-1:0] duty_in,
  output reg  [DW-1:0] duty_q
);
  // register output so the compare never sees a half-written duty
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      duty_q <= {DW{1'b0}};
    end else if (clear) begin
      duty_q <= {DW{1'b0}};
    end else if (load) begin
      duty_q <= duty_in;
    end
  end
endmodule
`default_nettype wire

// file: hdl/match_detect.v
// registered equality compare with a rising-match pulse
`timescale 1ns/1ps
`default_nettype none
module match_detect #(
  parameter W = 16
) (
  input  wire         clk_sys,
  input  wire         rst_b,
  input  wire         enable,
  input  wire [W-1:0] a,
  input  wire [W-1:0] b,
  output reg          hit_q
);
  reg eq_q;
  // one event per entry into equality; a timer held on the value fires once
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      eq_q  <= 1'b0;
      hit_q <= 1'b0;
    end else begin
      eq_q  <= enable && (a == b);
      hit_q <= enable && (a == b) && !eq_q;
    end
  end
endmodule
`default_nettype wire

// file: hdl/ccp_compare_and_pwm.v
// compare and pwm output side of a capture/compare/pwm unit
`timescale 1ns/1ps
`default_nettype none
`include "ccp_consts.vh"

module ccp_compare_and_pwm #(
  parameter CW          = 16,
  parameter TW          = 8,
  parameter IS_SECOND   = 0,
  parameter SINGLE_UNIT = 0
) (
  input  wire                   clk_sys,
  input  wire                   rst_b,
  input  wire [`CTRL_WIDTH-1:0] unit_control_reg,
  input  wire                   unit_control_wr,
  input  wire [CW-1:0]          compare_value_reg,
  input  wire [TW-1:0]          duty_high_byte,
  input  wire [CW-1:0]          timer1_count,
  input  wire [TW-1:0]          timer2_count,
  input  wire [TW-1:0]          timer2_period,
  input  wire                   timer2_tick,
  input  wire [1:0]             timer2_prescale,
  input  wire [1:0]             phase_bits,
  input  wire                   adc_enable,
  input  wire                   match_flag_clear,
  output reg                    unit_pin_q,
  output reg                    match_flag,
  output reg                    timer1_reset_q,
  output reg                    adc_start_q,
  output reg  [TW-1:0]          duty_shadow_byte,
  output reg  [1:0]             duty_low_latch_q,
  output reg                    pwm_active_q
);

  // ************************************************************
  // mode decode
  // ************************************************************
  wire [`CTRL_MODE_MSB:0] mode;
  wire                    is_pwm;
  wire                    is_cmp;
  wire                    ctrl_zero;
  wire [TW+1:0]           duty_new;
  wire [TW+1:0]           duty_buf;
  wire                    cmp_hit;
  wire                    period_end;
  wire [TW+1:0]           fine_next;
  reg  [1:0]              phase_sel;

  function is_mode;
    input [`CTRL_MODE_MSB:0] m;
    input [`CTRL_MODE_MSB:0] code;
    begin
      is_mode = (m == code);
    end
  endfunction

  assign mode      = unit_control_reg[`CTRL_MODE_MSB:0];
  assign is_pwm    = ((mode & `MODE_PWM_MASK) == `MODE_PWM_MASK);
  assign is_cmp    = mode[`CTRL_MODE_MSB] && !is_pwm;
  assign ctrl_zero = unit_control_wr && (unit_control_reg == {`CTRL_WIDTH{1'b0}});
  assign duty_new  = {duty_high_byte,
                      unit_control_reg[`CTRL_DLOW_MSB:`CTRL_DLOW_LSB]};

  // ************************************************************
  // compare path
  // ************************************************************
  // timer1 must run synchronously to this clock for the compare to hold
  match_detect #(
    .W (CW)
  ) u_match (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .enable  (is_cmp),
    .a       (timer1_count),
    .b       (compare_value_reg),
    .hit_q   (cmp_hit)
  );

  // ************************************************************
  // pwm timebase
  // ************************************************************
  // prescale 1, 4 and 16 all use the phase clock bits unchanged
  always @* begin
    case (timer2_prescale)
      `PRESC_1:  phase_sel = phase_bits;
      `PRESC_4:  phase_sel = phase_bits;
      `PRESC_16: phase_sel = phase_bits;
      default:   phase_sel = phase_bits;
    endcase
  end

  // period end comes from timer2 count against period; postscaler never seen
  assign period_end = timer2_tick && (timer2_count == timer2_period);
  // the pin is a register, so it is compared with the step the next edge shows;
  // that way it falls after exactly duty steps instead of one or two late
  assign fine_next  = {timer2_count, phase_sel} + {{TW{1'b0}}, `PHASE_INC};

  duty_buffer #(
    .DW (TW+2)
  ) u_duty (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .clear   (ctrl_zero),
    .load    (period_end && is_pwm),
    .duty_in (duty_new),
    .duty_q  (duty_buf)
  );

  // ************************************************************
  // output latch, flag and triggers
  // ************************************************************
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      unit_pin_q       <= 1'b0;
      match_flag       <= 1'b0;
      timer1_reset_q   <= 1'b0;
      adc_start_q      <= 1'b0;
      duty_shadow_byte <= {TW{1'b0}};
      duty_low_latch_q <= 2'h0;
      pwm_active_q     <= 1'b0;
    end else begin
      timer1_reset_q <= 1'b0;
      adc_start_q    <= 1'b0;
      pwm_active_q   <= is_pwm;
      // a new match wins over a simultaneous software clear
      if (cmp_hit && is_cmp) begin
        match_flag <= 1'b1;
      end else if (match_flag_clear) begin
        match_flag <= 1'b0;
      end
      if (ctrl_zero || mode == `MODE_OFF) begin
        unit_pin_q <= 1'b0;
      end else if (is_pwm) begin
        if (period_end) begin
          unit_pin_q       <= (duty_new != `ZERO_DUTY);
          duty_shadow_byte <= duty_high_byte;
          duty_low_latch_q <= duty_new[1:0];
        end else if (duty_buf == fine_next) begin
          // a duty past the period never equals the count, pin stays high
          unit_pin_q <= 1'b0;
        end
      end else if (cmp_hit) begin
        if (is_mode(mode, `MODE_CMP_SET)) begin
          unit_pin_q <= 1'b1;
        end else if (is_mode(mode, `MODE_CMP_CLR)) begin
          unit_pin_q <= 1'b0;
        end else if (is_mode(mode, `MODE_CMP_SPEV)) begin
          // reset pulse and adc start; the timer's overflow flag is not touched here
          timer1_reset_q <= 1'b1;
          adc_start_q    <= adc_enable && (IS_SECOND != 0 || SINGLE_UNIT != 0);
        end
        // software-interrupt mode keeps the pin
      end
    end
  end

endmodule
`default_nettype wire

// file: tb/ccp_checker_properties.sv
// port checker for the compare and pwm unit
`timescale 1ns/1ps
`default_nettype none
module ccp_checker #(
  parameter IS_SECOND   = 0,
  parameter SINGLE_UNIT = 0
) (
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic        unit_control_wr,
  input wire logic        timer2_tick,
  input wire logic        adc_enable,
  input wire logic        pwm_active_q,
  input wire logic        unit_pin_q,
  input wire logic        match_flag,
  input wire logic        timer1_reset_q,
  input wire logic        adc_start_q,
  input wire logic [5:0]  unit_control_reg,
  input wire logic [15:0] compare_value_reg,
  input wire logic [15:0] timer1_count,
  input wire logic [7:0]  duty_high_byte,
  input wire logic [7:0]  timer2_count,
  input wire logic [7:0]  timer2_period,
  input wire logic [7:0]  duty_shadow_byte
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire [3:0] md = unit_control_reg[3:0];
  // pwm taken from the live mode, as the unit itself does; its status output lags a cycle
  wire       pm = (md[3:2] == 2'h3);
  wire       pe = pm && timer2_tick && (timer2_count == timer2_period);
  // mode must hold for the whole two-cycle answer
  sequence hit(logic [3:0] c);
    $rose(timer1_count == compare_value_reg) && md == c ##1 md == c;
  endsequence
  set_pin_a: assert property (hit(4'h8) |-> ##1 unit_pin_q && match_flag)
    else $error("no set");
  clear_pin_a: assert property (hit(4'h9) |-> ##1 !unit_pin_q && match_flag)
    else $error("no clear");
  pin_kept_a: assert property (hit(4'hA) |-> ##1 $stable(unit_pin_q) && match_flag)
    else $error("pin moved");
  timer_reset_a: assert property (hit(4'hB) |-> ##1 timer1_reset_q ##1 !timer1_reset_q)
    else $error("no reset pulse");
  adc_start_a: assert property (timer1_reset_q |-> adc_start_q ==
    ((IS_SECOND != 0 || SINGLE_UNIT != 0) && $past(adc_enable))) else $error("bad start");
  start_alone_a: assert property (adc_start_q |-> timer1_reset_q)
    else $error("stray start");
  off_low_a: assert property (unit_control_wr && unit_control_reg == 6'h00
    |=> !unit_pin_q) else $error("not low");
  pwm_status_a: assert property (pwm_active_q == $past(pm))
    else $error("bad pwm status");
  shadow_load_a: assert property (pe |=> duty_shadow_byte == $past(duty_high_byte))
    else $error("stale shadow");
  period_start_a: assert property (pe |=> unit_pin_q ==
    ($past({duty_high_byte, unit_control_reg[5:4]}) != 10'h000)) else $error("bad period start");
endmodule
bind ccp_compare_and_pwm ccp_checker #(
  .IS_SECOND   (IS_SECOND),
  .SINGLE_UNIT (SINGLE_UNIT)
) i_ccp_checker (
  .clk_sys           (clk_sys),
  .rst_b             (rst_b),
  .unit_control_wr   (unit_control_wr),
  .timer2_tick       (timer2_tick),
  .adc_enable        (adc_enable),
  .pwm_active_q      (pwm_active_q),
  .unit_pin_q        (unit_pin_q),
  .match_flag        (match_flag),
  .timer1_reset_q    (timer1_reset_q),
  .adc_start_q       (adc_start_q),
  .unit_control_reg  (unit_control_reg),
  .compare_value_reg (compare_value_reg),
  .timer1_count      (timer1_count),
  .duty_high_byte    (duty_high_byte),
  .timer2_count      (timer2_count),
  .timer2_period     (timer2_period),
  .duty_shadow_byte  (duty_shadow_byte)
);
`default_nettype wire

// file: tb/pin_load.sv
// load on the unit pin, measures pulse and period
`timescale 1ns/1ps
`default_nettype none
module pin_load (
  input wire logic clk_sys,
  input wire logic pin,
  output logic [7:0] hi_len,
  output logic [7:0] per_len
);
  logic [7:0] hi = 8'h00, pd = 8'h00;
  logic last = 1'b0;
  always @(posedge clk_sys) begin
    last <= pin;
    hi <= pin ? hi + 8'h01 : 8'h00;
    pd <= (pin && !last) ? 8'h01 : pd + 8'h01;
    if (!pin && last) hi_len <= hi;
    if (pin && !last) per_len <= pd;
  end
endmodule
`default_nettype wire

// file: tb/tb_ccp_compare_and_pwm.sv
// self-checking bench for the compare and pwm unit
`timescale 1ns/1ps
`default_nettype none
module tb_ccp_compare_and_pwm;
  logic clk_sys = 1'b0, rst_b = 1'b0, wr = 1'b0, mclr = 1'b0, pin, flag, t1rst;
  logic aden = 1'b1, adst;
  logic [5:0] ctrl = 6'h00;
  logic [15:0] cmpv = 16'hFFFF, t1 = 16'h0000;
  logic [7:0] dhi = 8'h00, t2 = 8'h00, shd, hl, pl;
  logic [1:0] ph = 2'h0, dlo;
  int mismatches = 0, checks_done = 0, cyc = 0, np = 0, na = 0;
  always #10 clk_sys = ~clk_sys;
  // timers step just after the edge, as synchronous host timers would
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    // timers hold in reset: the unit's outputs are unknown before its first edge
    if (rst_b) begin
      np <= np + t1rst;
      na <= na + adst;
      t1 <= #1 t1rst ? 16'h0000 : t1 + 16'h0001;
      ph <= #1 ph + 2'h1;
      if (ph == 2'h3) t2 <= #1 (t2 == 8'h07) ? 8'h00 : t2 + 8'h01;
    end
    if (cyc == 2000) begin
      mismatches++;
      report_and_stop();
    end
  end
  ccp_compare_and_pwm #(.IS_SECOND(1)) i_ccp_compare_and_pwm (.clk_sys(clk_sys),
    .rst_b(rst_b), .unit_control_reg(ctrl), .unit_control_wr(wr), .compare_value_reg(cmpv),
    .duty_high_byte(dhi), .timer1_count(t1), .timer2_count(t2), .timer2_period(8'h07),
    .timer2_tick(ph == 2'h3), .timer2_prescale(2'h0), .phase_bits(ph), .adc_enable(aden),
    .match_flag_clear(mclr), .unit_pin_q(pin), .match_flag(flag), .timer1_reset_q(t1rst),
    .adc_start_q(adst), .duty_shadow_byte(shd), .duty_low_latch_q(dlo), .pwm_active_q());
  pin_load i_pin_load (.clk_sys(clk_sys), .pin(pin), .hi_len(hl), .per_len(pl));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic set_ctrl(input logic [5:0] v);
    @(posedge clk_sys);
    #1 ctrl = v;
    wr = 1'b1;
    mclr = 1'b1;
    @(posedge clk_sys);
    #1 wr = 1'b0;
    mclr = 1'b0;
  endtask
  task automatic t_compare(input logic [3:0] m, input logic p);
    int n, a;
    set_ctrl({2'h0, m});
    chk(flag, 1'b0);
    n = np;
    a = na;
    cmpv = t1 + 16'h0006;
    repeat (10) @(posedge clk_sys);
    #1 chk(pin, p);
    chk(flag, 1'b1);
    chk(np - n, m == 4'hB);
    chk(na - a, m == 4'hB && aden);
  endtask
  task automatic t_off;
    set_ctrl(6'h00);
    @(posedge clk_sys);
    #1 chk(pin, 1'b0);
  endtask
  task automatic t_pwm(input logic [9:0] d);
    dhi = d[9:2];
    set_ctrl({d[1:0], 4'hC});
    repeat (100) @(posedge clk_sys);
    #1 chk(shd, d[9:2]);
    chk(dlo, d[1:0]);
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    t_compare(4'h8, 1'b1);
    t_compare(4'hA, 1'b1);
    t_compare(4'h9, 1'b0);
    t_compare(4'hB, 1'b0);
    aden = 1'b0;
    t_compare(4'hB, 1'b0);
    aden = 1'b1;
    t_compare(4'h8, 1'b1);
    t_off();
    t_pwm(10'h00D);
    chk(pl, {8'h08, 2'h0});
    chk(hl, 8'h0D);
    t_pwm(10'h3FF);
    chk(pin, 1'b1);
    t_off();
    t_pwm(10'h000);
    chk(pin, 1'b0);
    report_and_stop();
  end
endmodule
`default_nettype wire
